/* vis_sequencer.sv */
`timescale 1ns/1ps
`include "vis_cfg.svh"
//------------------------------------------------------------
//------------------------------------------------------------
module vis_sequencer (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// avalon-mm slave
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// processor sequencer
	input wire vis_pkg::vis_cpu_req_type cpu_req_in,
	output vis_pkg::vis_cpu_cmd_type cpu_cmd_out,
	// interrupt sources
	input wire vis_pkg::vis_events_type events_in,
	input wire logic external_pin_in,
	input wire logic [7:0] wake_enable_mask_in,
	input wire logic [7:0] wake_pending_mask_in,
	// vector select rank of the current winner
	output logic [4:0] vector_rank_out
);
	import vis_pkg::*;

	//------------------------------------------------------------
	// state
	//------------------------------------------------------------
	vis_state_type state;
	logic [2:0] ack_step;
	logic global_interrupt_enable;
	logic port_wake_group_enable;
	logic [6:0] irq_enable;
	logic [6:0] pend_flags;
	logic trap_request;
	logic trap_active;
	logic trap_taken;
	logic [14:0] return_addr;
	logic ext_sync_a;
	logic ext_sync_b;
	logic ext_prev;
	logic bus_ack;
	logic [6:0] pend_view;
	logic [6:0] qualified;
	logic maskable_ok;
	logic take_any;
	logic take_now;
	logic ack_done;
	logic [6:0] next_pend;
	logic [6:0] set_mask;
	logic [6:0] clr_mask;
	logic bus_wr;
	logic bus_rd;
	logic cmd_ack_active;
	logic cmd_push;
	logic [14:0] cmd_push_addr;
	logic cmd_pc_load;
	logic [14:0] cmd_pc_addr;

	//------------------------------------------------------------
	// ranking
	//------------------------------------------------------------
	// fixed order, reserved slots never request
	function automatic logic [4:0] vis_rank(input logic trap, input logic [6:0] req);
		logic [4:0] r;
		r = `VIS_RANK_DEFAULT;
		if (trap) begin
			r = `VIS_RANK_TRAP;
		end else if (req[`VIS_SRC_EXTERNAL]) begin
			r = `VIS_RANK_EXTERNAL;
		end else if (req[`VIS_SRC_IDLE_TIMER]) begin
			r = `VIS_RANK_IDLE_TIMER;
		end else if (req[`VIS_SRC_TIMER_A]) begin
			r = `VIS_RANK_TIMER_A;
		end else if (req[`VIS_SRC_TIMER_B]) begin
			r = `VIS_RANK_TIMER_B;
		end else if (req[`VIS_SRC_SERIAL]) begin
			r = `VIS_RANK_SERIAL;
		end else if (req[`VIS_SRC_CAPTURE]) begin
			r = `VIS_RANK_CAPTURE;
		end else if (req[`VIS_SRC_PORT_WAKE]) begin
			r = `VIS_RANK_PORT_WAKE;
		end
		return r;
	endfunction

	//------------------------------------------------------------
	// register decode
	//------------------------------------------------------------
	// a landed bus write to one register with byte lane 0 enabled
	function automatic logic vis_reg_hit(input logic wr, input logic [3:0] addr,
		input logic [3:0] be, input logic [3:0] target);
		return wr && (addr == target) && be[0];
	endfunction

	//------------------------------------------------------------
	// external pin synchroniser and edge
	//------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ext_sync_a <= 1'b0;
			ext_sync_b <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			ext_sync_a <= external_pin_in;
			ext_sync_b <= ext_sync_a;
			ext_prev <= ext_sync_b;
		end
	end

	//------------------------------------------------------------
	// request qualification
	//------------------------------------------------------------
	always_comb begin
		pend_view = pend_flags;
		// wake has no flag of its own; the pin pending mask serves
		pend_view[`VIS_SRC_PORT_WAKE] = port_wake_group_enable &
			(|(wake_enable_mask_in & wake_pending_mask_in));
	end

	// idle timer uses irq_enable bit 1 like the others
	assign qualified = pend_view & irq_enable;
	assign maskable_ok = global_interrupt_enable & ~trap_active;
	assign take_any = trap_request | (maskable_ok & (|qualified));
	// a skipped slot is not an instruction start
	assign take_now = (state == VIS_RUN) & cpu_req_in.instr_start &
		~cpu_req_in.skip & take_any;
	assign ack_done = (state == VIS_ACK) & cpu_req_in.instr_cycle &
		(ack_step == (`VIS_ACK_CYCLES - 3'h1));
	assign trap_taken = take_now & trap_request;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			vector_rank_out <= `VIS_RANK_DEFAULT;
		end else begin
			// vector select runs inside a routine with global enable cleared,
			// so the rank ignores it; a running trap routine still ranks first
			vector_rank_out <= vis_rank(trap_request | trap_active,
				qualified);
		end
	end

	//------------------------------------------------------------
	// pending flags
	//------------------------------------------------------------
	always_comb begin
		set_mask = 7'h00;
		set_mask[`VIS_SRC_EXTERNAL] = ext_sync_b & ~ext_prev;
		set_mask[`VIS_SRC_IDLE_TIMER] = events_in.idle_timer;
		set_mask[`VIS_SRC_TIMER_A] = events_in.timer_a;
		set_mask[`VIS_SRC_TIMER_B] = events_in.timer_b;
		set_mask[`VIS_SRC_SERIAL] = events_in.serial;
		set_mask[`VIS_SRC_CAPTURE] = events_in.capture;
		clr_mask = 7'h00;
		if (vis_reg_hit(bus_wr, avs_address_in, avs_byteenable_in, `VIS_REG_PENDING)) begin
			clr_mask = avs_writedata_in[6:0];
		end
		// set beats clear, acknowledge never clears
		next_pend = ((pend_flags & ~clr_mask) | set_mask) & 7'h3f;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pend_flags <= `VIS_RST_PENDING;
		end else begin
			pend_flags <= next_pend;
		end
	end

	//------------------------------------------------------------
	// trap request and trap routine
	//------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			trap_request <= 1'b0;
		end else if (cpu_req_in.trap) begin
			trap_request <= 1'b1;
		end else if (trap_taken) begin
			trap_request <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			trap_active <= 1'b0;
		end else if (trap_taken) begin
			trap_active <= 1'b1;
		end else if (cpu_req_in.return_from_interrupt) begin
			trap_active <= 1'b0;
		end
	end

	//------------------------------------------------------------
	// global enable
	//------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			global_interrupt_enable <= 1'b0;
		end else if (take_now) begin
			global_interrupt_enable <= 1'b0;
		end else if (cpu_req_in.return_from_interrupt) begin
			global_interrupt_enable <= 1'b1;
		end else if (cpu_req_in.psw_gie_we) begin
			global_interrupt_enable <= cpu_req_in.psw_gie;
		end else if (vis_reg_hit(bus_wr, avs_address_in, avs_byteenable_in,
			`VIS_REG_CONTROL)) begin
			global_interrupt_enable <= avs_writedata_in[`VIS_CTL_GIE_BIT];
		end
	end

	//------------------------------------------------------------
	// acknowledge sequence
	//------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= VIS_RUN;
			ack_step <= 3'h0;
			return_addr <= 15'h0000;
		end else begin
			case (state)
				VIS_RUN: begin
					if (take_now) begin
						state <= VIS_ACK;
						ack_step <= 3'h0;
						return_addr <= cpu_req_in.next_pc;
					end
				end
				VIS_ACK: begin
					if (ack_done) begin
						state <= VIS_RUN;
						ack_step <= 3'h0;
					end else if (cpu_req_in.instr_cycle) begin
						ack_step <= ack_step + 3'h1;
					end
				end
				default: begin
					state <= VIS_RUN;
					ack_step <= 3'h0;
				end
			endcase
		end
	end

	//------------------------------------------------------------
	// commands to the sequencer and stack
	//------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmd_ack_active <= 1'b0;
		end else begin
			cmd_ack_active <= (state == VIS_RUN) ? take_now : ~ack_done;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmd_push <= 1'b0;
			cmd_push_addr <= 15'h0000;
		end else begin
			cmd_push <= (state == VIS_ACK) & cpu_req_in.instr_cycle &
				(ack_step == (`VIS_ACK_PUSH_STEP - 3'h1));
			cmd_push_addr <= return_addr;
		end
	end

	// pc load from a return beats nothing; a return cannot run inside acknowledge
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmd_pc_load <= 1'b0;
			cmd_pc_addr <= 15'h0000;
		end else if (ack_done) begin
			cmd_pc_load <= 1'b1;
			cmd_pc_addr <= `VIS_ENTRY_POINT;
		end else if (cpu_req_in.return_from_interrupt && state == VIS_RUN) begin
			cmd_pc_load <= 1'b1;
			cmd_pc_addr <= cpu_req_in.pop_addr;
		end else begin
			cmd_pc_load <= 1'b0;
		end
	end

	always_comb begin
		cpu_cmd_out = '0;
		cpu_cmd_out.ack_active = cmd_ack_active;
		cpu_cmd_out.push = cmd_push;
		cpu_cmd_out.push_addr = cmd_push_addr;
		cpu_cmd_out.pc_load = cmd_pc_load;
		cpu_cmd_out.pc_addr = cmd_pc_addr;
	end

	//------------------------------------------------------------
	// register bus
	//------------------------------------------------------------
	// one wait state on every access keeps readdata a flop
	assign bus_wr = avs_write_in & bus_ack;
	assign bus_rd = avs_read_in & bus_ack;
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~bus_ack;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= (avs_read_in | avs_write_in) & ~bus_ack;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			port_wake_group_enable <= 1'b0;
		end else if (vis_reg_hit(bus_wr, avs_address_in, avs_byteenable_in,
			`VIS_REG_CONTROL)) begin
			port_wake_group_enable <= avs_writedata_in[`VIS_CTL_WAKE_GRP_BIT];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_enable <= `VIS_RST_ENABLE;
		end else if (vis_reg_hit(bus_wr, avs_address_in, avs_byteenable_in,
			`VIS_REG_ENABLE)) begin
			irq_enable <= avs_writedata_in[6:0];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			avs_readdata_out <= 32'h00000000;
		end else if ((avs_read_in | avs_write_in) && !bus_ack) begin
			case (avs_address_in)
				`VIS_REG_CONTROL: begin
					avs_readdata_out <= {29'h0, trap_active, port_wake_group_enable,
						global_interrupt_enable};
				end
				`VIS_REG_ENABLE: begin
					avs_readdata_out <= {25'h0, irq_enable};
				end
				`VIS_REG_PENDING: begin
					avs_readdata_out <= {24'h0, trap_request, pend_view};
				end
				`VIS_REG_STATUS: begin
					avs_readdata_out <= {26'h0, (state == VIS_ACK), vector_rank_out};
				end
				default: begin
					avs_readdata_out <= 32'h00000000;
				end
			endcase
		end
	end

endmodule

/* vis_cfg.svh */
`ifndef VIS_CFG_SVH
`define VIS_CFG_SVH

// register byte offsets
`define VIS_REG_CONTROL 4'h0
`define VIS_REG_ENABLE 4'h4
`define VIS_REG_PENDING 4'h8
`define VIS_REG_STATUS 4'hc

// control register fields
`define VIS_CTL_GIE_BIT 0
`define VIS_CTL_WAKE_GRP_BIT 1
`define VIS_CTL_NMI_BIT 2

// maskable source positions in the enable and pending registers
`define VIS_SRC_EXTERNAL 0
`define VIS_SRC_IDLE_TIMER 1
`define VIS_SRC_TIMER_A 2
`define VIS_SRC_TIMER_B 3
`define VIS_SRC_SERIAL 4
`define VIS_SRC_CAPTURE 5
`define VIS_SRC_PORT_WAKE 6
`define VIS_NUM_MASKABLE 7

// arbitration ranks, 1 is highest
`define VIS_RANK_TRAP 5'h01
`define VIS_RANK_EXTERNAL 5'h03
`define VIS_RANK_IDLE_TIMER 5'h04
`define VIS_RANK_TIMER_A 5'h05
`define VIS_RANK_TIMER_B 5'h06
`define VIS_RANK_SERIAL 5'h07
`define VIS_RANK_CAPTURE 5'h0b
`define VIS_RANK_PORT_WAKE 5'h0f
`define VIS_RANK_DEFAULT 5'h10

// entry point and acknowledge length
`define VIS_ENTRY_POINT 15'h00ff
`define VIS_ACK_CYCLES 3'h7
`define VIS_ACK_PUSH_STEP 3'h2

// reset values
`define VIS_RST_CONTROL 2'h0
`define VIS_RST_ENABLE 7'h00
`define VIS_RST_PENDING 7'h00

`endif

/* vis_pkg.sv */
package vis_pkg;

	typedef enum logic [0:0] {
		VIS_RUN,
		VIS_ACK
	} vis_state_type;

	// requests from the processor sequencer, all on clk_in
	typedef struct packed {
		logic instr_cycle;
		logic instr_start;
		logic skip;
		logic trap;
		logic return_from_interrupt;
		logic psw_gie_we;
		logic psw_gie;
		logic [14:0] next_pc;
		logic [14:0] pop_addr;
	} vis_cpu_req_type;

	// commands back to the sequencer and stack
	typedef struct packed {
		logic ack_active;
		logic push;
		logic [14:0] push_addr;
		logic pc_load;
		logic [14:0] pc_addr;
	} vis_cpu_cmd_type;

	// peripheral event pulses, same clock
	typedef struct packed {
		logic idle_timer;
		logic timer_a;
		logic timer_b;
		logic serial;
		logic capture;
	} vis_events_type;

endpackage

/* vis_seq_assertions.sv */
`timescale 1ns/1ps
module vis_seq_chk (
	// watched ports
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire vis_pkg::vis_cpu_req_type cpu_req_in,
	input wire vis_pkg::vis_cpu_cmd_type cpu_cmd_out,
	input wire logic [4:0] vector_rank_out
);
	import vis_pkg::*;
	//------------------------------------------------
	// properties, one instruction cycle per clock
	//------------------------------------------------
	logic ack;
	logic start;
	assign ack = cpu_cmd_out.ack_active;
	assign start = cpu_req_in.instr_start;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	property p_entry;
		cpu_cmd_out.pc_load && $past(ack) |-> cpu_cmd_out.pc_addr == 15'h00ff;
	endproperty
	property p_ack_len;
		$rose(ack) |-> ack[*7] ##1 (!ack && cpu_cmd_out.pc_load);
	endproperty
	property p_push;
		$rose(ack) |-> ##2 (cpu_cmd_out.push &&
			cpu_cmd_out.push_addr == $past(cpu_req_in.next_pc, 3));
	endproperty
	property p_push_in_ack;
		cpu_cmd_out.push |-> ack && $past(ack);
	endproperty
	property p_skip;
		start && cpu_req_in.skip && !ack |=> !ack;
	endproperty
	property p_no_start;
		!start && !ack |=> !ack;
	endproperty
	property p_return_from_interrupt;
		cpu_req_in.return_from_interrupt && !ack |=> cpu_cmd_out.pc_load && cpu_cmd_out.pc_addr == $past(cpu_req_in.pop_addr);
	endproperty
	property p_rank;
		vector_rank_out inside {5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0b, 5'h0f, 5'h10};
	endproperty
	a_entry: assert property (p_entry) else $error("entry address wrong");
	a_ack_len: assert property (p_ack_len) else $error("acknowledge length wrong");
	a_push: assert property (p_push) else $error("pushed address wrong");
	a_push_in_ack: assert property (p_push_in_ack) else $error("push outside ack");
	a_skip: assert property (p_skip) else $error("ack on skipped start");
	a_no_start: assert property (p_no_start) else $error("ack without start");
	a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return load wrong");
	a_rank: assert property (p_rank) else $error("rank outside table");
	c_ack: cover property ($rose(ack));
	c_return_from_interrupt: cover property (cpu_req_in.return_from_interrupt);
	c_trap: cover property (vector_rank_out == 5'h01);
endmodule
bind vis_sequencer vis_seq_chk u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.cpu_req_in(cpu_req_in), .cpu_cmd_out(cpu_cmd_out), .vector_rank_out(vector_rank_out));

/* vis_cpu_model.sv */
`timescale 1ns/1ps
module vis_cpu_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// bench controls
	input wire logic trap_in,
	input wire logic return_from_interrupt_in,
	input wire logic skip_in,
	input wire logic gie_we_in,
	input wire logic gie_in,
	// sequencer side
	input wire vis_pkg::vis_cpu_cmd_type cmd_in,
	output vis_pkg::vis_cpu_req_type req_out
);
	import vis_pkg::*;
	//------------------------------------------------
	// two-cycle instructions, stack in a queue
	//------------------------------------------------
	logic phase;
	logic return_from_interrupt_q;
	logic [14:0] pc;
	logic [14:0] stack [$];
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			phase <= 1'b0;
			pc <= 15'h0100;
			return_from_interrupt_q <= 1'b0;
		end else begin
			phase <= !cmd_in.ack_active && !phase;
			// pop one edge late so the sequencer reads the old top at the return edge
			return_from_interrupt_q <= return_from_interrupt_in;
			if (cmd_in.push)
				stack.push_back(cmd_in.push_addr);
			if (return_from_interrupt_q && stack.size() > 0)
				void'(stack.pop_back());
			if (cmd_in.pc_load)
				pc <= cmd_in.pc_addr;
			else if (phase)
				pc <= pc + 15'h1;
		end
	end
	always_comb begin
		req_out = '0;
		req_out.instr_cycle = rst_n_in;
		req_out.instr_start = phase && !cmd_in.ack_active;
		req_out.skip = skip_in;
		req_out.trap = trap_in;
		req_out.return_from_interrupt = return_from_interrupt_in;
		req_out.psw_gie_we = gie_we_in;
		req_out.psw_gie = gie_in;
		req_out.next_pc = pc;
		// empty stack shows a changing value, never the last one
		req_out.pop_addr = (stack.size() > 0) ? stack[$] : ~pc;
	end
endmodule

/* vis_sequencer_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_total++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module vis_sequencer_tb;
	import vis_pkg::*;
	//------------------------------------------------
	// wiring
	//------------------------------------------------
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [3:0] addr = 4'h0;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] q;
	logic waitreq;
	logic [4:0] rank;
	vis_cpu_req_type req;
	vis_cpu_cmd_type cmd;
	vis_events_type ev = '0;
	logic ext = 1'b0;
	logic [7:0] wk_en = 8'h00;
	logic [7:0] wk_pnd = 8'h00;
	logic trap = 1'b0;
	logic return_from_interrupt = 1'b0;
	logic skip = 1'b0;
	logic gwe = 1'b0;
	int err_total = 0;
	int compares = 0;
	int cycles = 0;
	logic [4:0] rk [6] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0b};
	always #5 clk_in = !clk_in;
	vis_sequencer uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(addr),
		.avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdata),
		.avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
		.cpu_req_in(req), .cpu_cmd_out(cmd), .events_in(ev), .external_pin_in(ext),
		.wake_enable_mask_in(wk_en), .wake_pending_mask_in(wk_pnd), .vector_rank_out(rank));
	vis_cpu_model u_cpu (.clk_in(clk_in), .rst_n_in(rst_n_in), .trap_in(trap), .return_from_interrupt_in(return_from_interrupt),
		.skip_in(skip), .gie_we_in(gwe), .gie_in(1'b1), .cmd_in(cmd), .req_out(req));
	//------------------------------------------------
	// tasks
	//------------------------------------------------
	task automatic report_and_stop();
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		wr_en <= w;
		rd_en <= !w;
		wdata <= d;
		// waitrequest is looked at between edges, where it has settled
		@(negedge clk_in);
		while (waitreq)
			@(negedge clk_in);
		@(posedge clk_in);
		q = rdata;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK($sformatf("reg %h", a), e, q)
	endtask
	task automatic wait_load();
		@(negedge clk_in);
		while (!cmd.pc_load)
			@(negedge clk_in);
		`CHK("pc_addr", 15'h00ff, cmd.pc_addr)
		@(posedge clk_in);
	endtask
	task automatic return_from_interrupt_go();
		return_from_interrupt <= 1'b1;
		@(posedge clk_in);
		return_from_interrupt <= 1'b0;
		@(negedge clk_in);
		`CHK("return_from_interrupt load", 1'b1, cmd.pc_load)
		@(posedge clk_in);
	endtask
	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			report_and_stop();
		end
	end
	//------------------------------------------------
	// sequence
	//------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rd(4'h0, 32'h0);
		rd(4'h4, 32'h0);
		rd(4'h8, 32'h0);
		rd(4'hc, 32'h10);
		rd(4'h2, 32'h0);
		ev <= '1;
		ext <= 1'b1;
		@(posedge clk_in);
		ev <= '0;
		repeat (4) @(posedge clk_in);
		rd(4'h8, 32'h3f);
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, 4'h4, 32'h1 << i);
			rd(4'hc, {27'h0, rk[i]});
		end
		bus(1'b1, 4'h0, 32'h2);
		wk_en <= 8'h10;
		wk_pnd <= 8'h10;
		bus(1'b1, 4'h4, 32'h40);
		rd(4'hc, 32'h0f);
		rd(4'h8, 32'h7f);
		bus(1'b1, 4'h4, 32'h7f);
		bus(1'b1, 4'h0, 32'h3);
		wait_load();
		rd(4'h0, 32'h2);
		rd(4'h8, 32'h7f);
		rd(4'hc, 32'h03);
		gwe <= 1'b1;
		@(posedge clk_in);
		gwe <= 1'b0;
		wait_load();
		return_from_interrupt_go();
		wait_load();
		bus(1'b1, 4'h4, 32'h0);
		trap <= 1'b1;
		@(posedge clk_in);
		trap <= 1'b0;
		wait_load();
		rd(4'hc, 32'h01);
		`CHK("rank", 5'h01, rank)
		bus(1'b1, 4'h4, 32'h7f);
		gwe <= 1'b1;
		@(posedge clk_in);
		gwe <= 1'b0;
		repeat (10) @(posedge clk_in);
		rd(4'h0, 32'h7);
		return_from_interrupt_go();
		wait_load();
		skip <= 1'b1;
		bus(1'b1, 4'h0, 32'h3);
		repeat (10) @(posedge clk_in);
		rd(4'h0, 32'h3);
		skip <= 1'b0;
		wait_load();
		bus(1'b1, 4'h8, 32'h3f);
		rd(4'h8, 32'h40);
		report_and_stop();
	end
endmodule
